// ==== smid_datapath.sv ====
/*
  Datapath for logical right shift, register move and indirect load.
  Assumes the decoder presents op, operands and file data for one cycle,
  and that indirect target data arrives combinationally for read_addr.
*/
module smid_datapath
  import smid_pkg::*;
#(
  parameter int DATA_W = SMID_DATA_W,
  parameter int PTR_W  = SMID_PTR_W,
  parameter int OFS_W  = SMID_OFS_W
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // decoded instruction
  input  wire smid_op_t          op,
  input  wire logic              dest_file,
  input  wire logic [DATA_W-1:0] file_data,
  // indirect load controls
  input  wire logic              ptr_sel,
  input  wire logic [1:0]        ptr_mode,
  input  wire logic              ptr_relative,
  input  wire logic [OFS_W-1:0]  ptr_offset,
  input  wire logic [DATA_W-1:0] indirect_target,
  // indirect address to the file array
  output logic      [PTR_W-1:0]  indirect_addr,
  // file write-back
  output logic                   file_we,
  output logic      [DATA_W-1:0] file_wdata,
  // architectural state
  output logic      [DATA_W-1:0] acc,
  output logic                   carry,
  output logic                   zero,
  output logic      [PTR_W-1:0]  indirect_pointer0,
  output logic      [PTR_W-1:0]  indirect_pointer1
);
  // ------------------------------------------------------------
  // pointer arithmetic
  // ------------------------------------------------------------
  logic [PTR_W-1:0] sel_ptr;
  logic [PTR_W-1:0] calc_ptr;
  logic [PTR_W-1:0] next_indirect_pointer0;
  logic [PTR_W-1:0] next_indirect_pointer1;
  logic [PTR_W-1:0] next_indirect_addr;

  assign sel_ptr = ptr_sel ? indirect_pointer1 : indirect_pointer0;

  smid_ptr_calc #(
    .PTR_W (PTR_W),
    .OFS_W (OFS_W)
  ) u_ptr (
    .ptr       (sel_ptr),
    .mode      (ptr_mode),
    .relative  (ptr_relative),
    .offset    (ptr_offset),
    .read_addr (next_indirect_addr),
    .next_ptr  (calc_ptr)
  );

  // address is computed combinationally but leaves the module only through
  // the indirect_addr register, one cycle after the op is taken
  logic [PTR_W-1:0] live_addr;
  assign live_addr = next_indirect_addr;

  // ------------------------------------------------------------
  // result and flags
  // ------------------------------------------------------------
  logic [DATA_W-1:0] result;
  logic              affects;
  logic [DATA_W-1:0] next_acc;
  logic              next_carry;
  logic              next_zero;
  logic              next_file_we;
  logic [DATA_W-1:0] next_file_wdata;

  always_comb
  begin
    result                 = '0;
    affects                = 1'b0;
    next_acc               = acc;
    next_carry             = carry;
    next_zero              = zero;
    next_file_we           = 1'b0;
    next_file_wdata        = file_wdata;
    next_indirect_pointer0 = indirect_pointer0;
    next_indirect_pointer1 = indirect_pointer1;
    unique case (op)
      SMID_OP_NONE:
      begin
      end
      SMID_OP_SHIFT:
      begin
        result     = {1'b0, file_data[DATA_W-1:1]};
        next_carry = file_data[0];
        affects    = 1'b1;
      end
      SMID_OP_MOVE:
      begin
        result  = file_data;
        affects = 1'b1;
      end
      SMID_OP_INDIRECT:
      begin
        result   = indirect_target;
        affects  = 1'b1;
        next_acc = indirect_target;
        if (ptr_sel)
          next_indirect_pointer1 = calc_ptr;
        else
          next_indirect_pointer0 = calc_ptr;
      end
    endcase
    if (op == SMID_OP_SHIFT || op == SMID_OP_MOVE)
    begin
      if (dest_file)
      begin
        next_file_we    = 1'b1;
        next_file_wdata = result;
      end
      else
        next_acc = result;
    end
    if (affects)
      next_zero = (result == '0);
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      acc               <= SMID_ACC_RST;
      carry             <= 1'b0;
      zero              <= 1'b0;
      file_we           <= 1'b0;
      file_wdata        <= SMID_ACC_RST;
      indirect_pointer0 <= SMID_PTR_RST;
      indirect_pointer1 <= SMID_PTR_RST;
      indirect_addr     <= SMID_PTR_RST;
    end
    else
    begin
      acc               <= next_acc;
      carry             <= next_carry;
      zero              <= next_zero;
      file_we           <= next_file_we;
      file_wdata        <= next_file_wdata;
      indirect_pointer0 <= next_indirect_pointer0;
      indirect_pointer1 <= next_indirect_pointer1;
      indirect_addr     <= live_addr;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_shift_to_acc;
    op == SMID_OP_SHIFT && !dest_file;
  endsequence

  AST_SHIFT_BITS: assert property (
    s_shift_to_acc |=> acc[6:0] == $past(file_data[7:1])
      && carry == $past(file_data[0]))
    else $error("shift bits or carry wrong");

  AST_SHIFT_MSB: assert property (
    op == SMID_OP_SHIFT |=> (file_we ? file_wdata[7] : acc[7]) == 1'b0)
    else $error("shift msb not zero");

  AST_SHIFT_DEST: assert property (
    op == SMID_OP_SHIFT && dest_file |=> file_we && acc == $past(acc))
    else $error("shift to file wrong");

  AST_MOVE_COPY: assert property (
    op == SMID_OP_MOVE && dest_file |=> file_wdata == $past(file_data))
    else $error("move data wrong");

  AST_MOVE_ZERO: assert property (
    op == SMID_OP_MOVE |=> zero == ($past(file_data) == 8'h00))
    else $error("move zero wrong");

  AST_PRE_INC: assert property (
    op == SMID_OP_INDIRECT && !ptr_relative && ptr_mode == SMID_PRE_INC
      |-> next_indirect_addr == sel_ptr + PTR_W'(1))
    else $error("preincrement address wrong");

  AST_REL_ADDR: assert property (
    op == SMID_OP_INDIRECT && ptr_relative
      |-> next_indirect_addr == sel_ptr + PTR_W'($signed(ptr_offset)))
    else $error("relative address wrong");

  AST_PTR_AFTER: assert property (
    op == SMID_OP_INDIRECT && !ptr_sel && !ptr_relative && !ptr_mode[0]
      |=> indirect_pointer0 == $past(indirect_pointer0) + PTR_W'(1))
    else $error("pointer increment wrong");

  AST_REL_KEEP: assert property (
    op == SMID_OP_INDIRECT && ptr_relative
      |=> indirect_pointer0 == $past(indirect_pointer0)
        && indirect_pointer1 == $past(indirect_pointer1))
    else $error("relative form changed pointer");

  AST_IND_ZERO: assert property (
    op == SMID_OP_INDIRECT |=> acc == $past(indirect_target)
      && zero == ($past(indirect_target) == 8'h00))
    else $error("indirect zero wrong");
endmodule // smid_datapath

// ==== smid_pkg.sv ====
/*
  Constants and types of the shift, move and indirect-load datapath.
  Assumes the core decoder supplies one decoded instruction per clock.
*/
package smid_pkg;
  localparam int          SMID_DATA_W   = 8;
  localparam int          SMID_PTR_W    = 16;
  localparam int          SMID_OFS_W    = 6;
  localparam logic [7:0]  SMID_ACC_RST  = 8'h00;
  localparam logic [15:0] SMID_PTR_RST  = 16'h0000;
  localparam logic [1:0]  SMID_PRE_INC  = 2'h0;
  localparam logic [1:0]  SMID_PRE_DEC  = 2'h1;
  localparam logic [1:0]  SMID_POST_INC = 2'h2;
  localparam logic [1:0]  SMID_POST_DEC = 2'h3;

  typedef enum logic [1:0] {
    SMID_OP_NONE,
    SMID_OP_SHIFT,
    SMID_OP_MOVE,
    SMID_OP_INDIRECT
  } smid_op_t;
endpackage

// ==== smid_ptr_calc.sv ====
/*
  Pointer arithmetic for the indirect load: read address and updated pointer.
  Assumes mode and offset are stable while the op is presented.
*/
module smid_ptr_calc
  import smid_pkg::*;
#(
  parameter int PTR_W = SMID_PTR_W,
  parameter int OFS_W = SMID_OFS_W
)(
  // pointer in
  input  wire logic [PTR_W-1:0] ptr,
  input  wire logic [1:0]       mode,
  input  wire logic             relative,
  input  wire logic [OFS_W-1:0] offset,
  // results
  output logic      [PTR_W-1:0] read_addr,
  output logic      [PTR_W-1:0] next_ptr
);
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] ofs_ext;

  always_comb
  begin
    ptr_inc = ptr + PTR_W'(1);
    ptr_dec = ptr - PTR_W'(1);
    ofs_ext = PTR_W'($signed(offset));
    if (relative)
    begin
      read_addr = ptr + ofs_ext;
      next_ptr  = ptr;
    end
    else
    begin
      unique case (mode)
        SMID_PRE_INC:  read_addr = ptr_inc;
        SMID_PRE_DEC:  read_addr = ptr_dec;
        SMID_POST_INC: read_addr = ptr;
        SMID_POST_DEC: read_addr = ptr;
      endcase
      next_ptr = mode[0] ? ptr_dec : ptr_inc;
    end
  end
endmodule // smid_ptr_calc

// ==== smid_file_model.sv ====
/*
  Model of the file array behind the indirect read path.
  Assumes the datapath's pointers and the decoder's indirect controls
  are stable through the cycle in which the load is presented.
*/
module smid_file_model
  import smid_pkg::*;
(
  // pointers from the datapath
  input  wire logic [15:0] ptr0,
  input  wire logic [15:0] ptr1,
  // indirect controls
  input  wire logic        sel,
  input  wire logic [1:0]  mode,
  input  wire logic        relative,
  input  wire logic [5:0]  offset,
  // data at the indirect address
  output logic      [7:0]  target
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] base;
  logic [15:0] addr;
  always_comb
  begin
    base = sel ? ptr1 : ptr0;
    if (relative)
      addr = base + {{10{offset[5]}}, offset};
    else if (mode == SMID_PRE_INC)
      addr = base + 16'h0001;
    else if (mode == SMID_PRE_DEC)
      addr = base - 16'h0001;
    else
      addr = base;
    // contents vary with every address bit so a wrong address shows
    target = addr[7:0] ^ addr[15:8] ^ 8'ha5;
  end
endmodule // smid_file_model

// ==== smid_datapath_tb.sv ====
/*
  Self-checking bench of the shift, move and indirect-load datapath.
  Assumes results of an op are visible the cycle after it is taken.
*/
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module smid_datapath_tb;
  import smid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  smid_op_t    op = SMID_OP_NONE;
  logic        dest_file = 1'b0;
  logic [7:0]  file_data = 8'h00;
  logic        ptr_sel = 1'b0;
  logic [1:0]  ptr_mode = 2'h0;
  logic        ptr_relative = 1'b0;
  logic [5:0]  ptr_offset = 6'h00;
  logic [7:0]  tgt;
  logic [15:0] indirect_addr, ptr0, ptr1;
  logic        file_we, carry, zero;
  logic [7:0]  file_wdata, acc;
  int          fails = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  smid_datapath i_dut (.clk(clk), .reset_n(reset_n), .op(op),
    .dest_file(dest_file), .file_data(file_data), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .ptr_relative(ptr_relative),
    .ptr_offset(ptr_offset), .indirect_target(tgt),
    .indirect_addr(indirect_addr), .file_we(file_we),
    .file_wdata(file_wdata), .acc(acc), .carry(carry), .zero(zero),
    .indirect_pointer0(ptr0), .indirect_pointer1(ptr1));
  smid_file_model i_model (.ptr0(ptr0), .ptr1(ptr1), .sel(ptr_sel),
    .mode(ptr_mode), .relative(ptr_relative), .offset(ptr_offset),
    .target(tgt));
  // ----------------------------------------
  // one op for one cycle, results at negedge
  // ----------------------------------------
  task automatic issue(input smid_op_t o, input logic d,
    input logic [7:0] fd, input logic s, input logic [1:0] m,
    input logic r, input logic [5:0] k);
    @(posedge clk);
    op <= o;
    dest_file <= d;
    file_data <= fd;
    ptr_sel <= s;
    ptr_mode <= m;
    ptr_relative <= r;
    ptr_offset <= k;
    @(posedge clk);
    op <= SMID_OP_NONE;
    @(negedge clk);
  endtask
  task automatic test_shift();
    issue(SMID_OP_SHIFT, 1'b0, 8'h81, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("acc", 8'h40, acc)
    `CHK("carry", 1'b1, carry)
    `CHK("zero", 1'b0, zero)
    `CHK("file_we", 1'b0, file_we)
    issue(SMID_OP_SHIFT, 1'b1, 8'h01, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("file_we", 1'b1, file_we)
    `CHK("file_wdata", 8'h00, file_wdata)
    `CHK("zero", 1'b1, zero)
    `CHK("acc", 8'h40, acc)
    // carry must fall again and the set msb must not survive
    issue(SMID_OP_SHIFT, 1'b0, 8'hfe, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("acc", 8'h7f, acc)
    `CHK("carry", 1'b0, carry)
    `CHK("zero", 1'b0, zero)
  endtask
  task automatic test_move();
    issue(SMID_OP_MOVE, 1'b1, 8'h5a, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("file_we", 1'b1, file_we)
    `CHK("file_wdata", 8'h5a, file_wdata)
    `CHK("acc", 8'h7f, acc)
    issue(SMID_OP_MOVE, 1'b0, 8'hc3, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("acc", 8'hc3, acc)
    `CHK("zero", 1'b0, zero)
    `CHK("file_we", 1'b0, file_we)
    // self-move of zero as a zero test
    issue(SMID_OP_MOVE, 1'b1, 8'h00, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("file_wdata", 8'h00, file_wdata)
    `CHK("zero", 1'b1, zero)
    `CHK("acc", 8'hc3, acc)
  endtask
  task automatic test_indirect();
    logic [15:0] p;
    logic [15:0] a;
    p = 16'h0000;
    for (int m = 0; m < 4; m++)
    begin
      a = (m == 0) ? p + 16'h0001 : (m == 1) ? p - 16'h0001 : p;
      issue(SMID_OP_INDIRECT, 1'b0, 8'h00, 1'b0, 2'(m), 1'b0, 6'h00);
      `CHK("indirect_addr", a, indirect_addr)
      `CHK("acc", a[7:0] ^ a[15:8] ^ 8'ha5, acc)
      `CHK("zero", 1'b0, zero)
      p = (m % 2 == 1) ? p - 16'h0001 : p + 16'h0001;
      `CHK("pointer0", p, ptr0)
    end
    // offset of -1 from pointer1 at zero wraps the address
    issue(SMID_OP_INDIRECT, 1'b0, 8'h00, 1'b1, 2'h0, 1'b1, 6'h3f);
    `CHK("indirect_addr", 16'hffff, indirect_addr)
    `CHK("acc", 8'ha5, acc)
    `CHK("pointer1", 16'h0000, ptr1)
    `CHK("pointer0", p, ptr0)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    test_shift();
    test_move();
    test_indirect();
    print_verdict();
  end
endmodule // smid_datapath_tb
